// ===== hw/weld_initiation_sequencer.sv
// Weld initiation sequencer: pilot inputs, schedule start, valves, weld gate
//
// Overview of operation
// - Third input starts at schedule 20
// - External select: inputs point, primary starts
// - Open emergency loop forces emergency stop
// - Weld current only with weld switch closed
// - Single stage start latched to completion
// - Repeat single stage while input closed
// - First stage energises valves when idle, no sequence
// - Each second-stage input starts own schedule
// - Started sequence continues if first stage opens
// - Ignore starts while sequence runs
// - Repeat two stage while a second-stage input closed
// - No-weld runs sequence, lights indicator, no current
// - Current only in weld interval, switch closed
// - Open weld switch means no-weld despite indicator
// - Second input starts at schedule 10
// - Primary input starts at displayed schedule
// - Estop drops outputs; needs fresh pilot closure
//
// Design decisions made here: the strobed register port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module weld_initiation_sequencer #(
  parameter int DEBOUNCE = weld_init_pkg::DEBOUNCE_CYCLES
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // Contact inputs, high when closed
  input wire logic first_stage_pilot_input_i,
  input wire logic primary_initiate_input_i,
  input wire logic second_initiate_pointer_low_i,
  input wire logic third_initiate_pointer_high_i,
  input wire logic emergency_stop_loop_input_i,
  input wire logic weld_enable_switch_input_i,
  // Sequence timing core handshake
  input wire logic [7:0] display_schedule_i,
  input wire logic weld_interval_i,
  input wire logic [2:0] schedule_valves_i,
  input wire logic seq_done_i,
  output logic seq_start_o,
  output logic [7:0] seq_schedule_o,
  output logic seq_active_o,
  // Plant outputs
  output logic solenoid_valve_one_output_o,
  output logic solenoid_valve_two_output_o,
  output logic solenoid_valve_three_output_o,
  output logic weld_current_o,
  output logic no_weld_led_o,
  output logic estop_o,
  // Register port
  input wire logic [3:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  output logic irq_o
);
  localparam int NIN = 6;

  // --------------------------------------------------------------------
  // Debounced inputs
  // --------------------------------------------------------------------
  logic [NIN-1:0] raw;
  logic [NIN-1:0] clean;
  assign raw = {weld_enable_switch_input_i, emergency_stop_loop_input_i,
                third_initiate_pointer_high_i, second_initiate_pointer_low_i,
                primary_initiate_input_i, first_stage_pilot_input_i};

  // One debouncer per contact
  for (genvar g = 0; g < NIN; g++) begin : g_db
    contact_debounce #(.COUNT(DEBOUNCE)) u_db (
      .clk_i(clk_i),
      .srst_i(srst_i),
      .raw_i(raw[g]),
      .clean_o(clean[g])
    );
  end

  logic first_stage;
  logic primary_in;
  logic second_in;
  logic third_in;
  logic loop_ok;
  logic weld_sw;
  assign first_stage = clean[0];
  assign primary_in = clean[1];
  assign second_in = clean[2];
  assign third_in = clean[3];
  assign loop_ok = clean[4];
  assign weld_sw = clean[5];

  // --------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------
  typedef struct packed {
    weld_init_pkg::seq_state_t st;
    logic [7:0] sched;
    logic [3:0] ctl;
    logic [weld_init_pkg::EVT_W-1:0] en;
    logic [weld_init_pkg::EVT_W-1:0] status;
    logic [7:0] rdata;
    logic start;
  } top_t;
  top_t s_reg;
  top_t s_next;

  logic ext_sel;
  logic two_stage;
  logic repeat_mode;
  logic any_start;
  logic any_pilot;
  logic [weld_init_pkg::EVT_W-1:0] evt;
  logic [7:0] start_sched;

  assign ext_sel = s_reg.ctl[weld_init_pkg::CTL_EXT_SEL];
  assign two_stage = s_reg.ctl[weld_init_pkg::CTL_TWO_STAGE];
  assign repeat_mode = s_reg.ctl[weld_init_pkg::CTL_REPEAT];
  // Under external select only the primary input starts
  assign any_start = ext_sel ? primary_in : (primary_in | second_in | third_in);
  assign any_pilot = any_start | (two_stage & first_stage);

  // Start schedule: pointer inputs under external select, else priority primary, then second, then third input
  always_comb begin
    if (ext_sel) begin
      start_sched = weld_init_pkg::SCHED_EXT_BASE + {6'h00, third_in, second_in};
    end else if (primary_in) begin
      start_sched = display_schedule_i;
    end else if (second_in) begin
      start_sched = weld_init_pkg::SCHED_SECOND_START;
    end else begin
      start_sched = weld_init_pkg::SCHED_THIRD_START;
    end
  end

  // Sequencer, registers and events
  always_comb begin
    s_next = s_reg;
    s_next.start = 1'b0;
    evt = '0;
    unique case (s_reg.st)
      weld_init_pkg::ST_IDLE: begin
        if (any_start) begin
          s_next.st = weld_init_pkg::ST_RUN;
          s_next.sched = start_sched;
          s_next.start = 1'b1;
          evt[weld_init_pkg::EVT_START] = 1'b1;
        end
      end
      weld_init_pkg::ST_RUN: begin
        // Latched: pilot state ignored until done
        if (seq_done_i) begin
          s_next.st = weld_init_pkg::ST_DONE;
          evt[weld_init_pkg::EVT_DONE] = 1'b1;
        end
      end
      weld_init_pkg::ST_DONE: begin
        // Repeat while pilot held, else wait for release
        if (repeat_mode && (two_stage ? any_pilot : any_start) && any_start) begin
          s_next.st = weld_init_pkg::ST_RUN;
          s_next.sched = start_sched;
          s_next.start = 1'b1;
          evt[weld_init_pkg::EVT_START] = 1'b1;
        end else if (repeat_mode && two_stage && first_stage) begin
          s_next.st = weld_init_pkg::ST_DONE;
        end else if (any_start) begin
          s_next.st = weld_init_pkg::ST_WAIT_OPEN;
        end else begin
          s_next.st = weld_init_pkg::ST_IDLE;
        end
      end
      weld_init_pkg::ST_ESTOP: begin
        if (loop_ok) begin
          s_next.st = weld_init_pkg::ST_WAIT_OPEN;
          evt[weld_init_pkg::EVT_RELEASE] = 1'b1;
        end
      end
      weld_init_pkg::ST_WAIT_OPEN: begin
        // Fresh closure needed after release or completion
        if (!any_start) begin
          s_next.st = weld_init_pkg::ST_IDLE;
        end
      end
    endcase
    // Open loop overrides next state and start pulse; that cycle's events and schedule still latch
    if (!loop_ok) begin
      s_next.st = weld_init_pkg::ST_ESTOP;
      s_next.start = 1'b0;
      if (s_reg.st != weld_init_pkg::ST_ESTOP) begin
        evt[weld_init_pkg::EVT_ESTOP] = 1'b1;
      end
    end
    // Register writes; new events win over clear
    if (wr_i) begin
      unique case (addr_i)
        weld_init_pkg::ADDR_CLEAR: s_next.status = s_reg.status & ~wdata_i[3:0];
        weld_init_pkg::ADDR_ENABLE: s_next.en = wdata_i[3:0];
        weld_init_pkg::ADDR_CONTROL: s_next.ctl = wdata_i[3:0];
        default: begin
        end
      endcase
    end
    s_next.status = s_next.status | evt;
    // Read data, one cycle later
    s_next.rdata = 8'h00;
    if (rd_i) begin
      unique case (addr_i)
        weld_init_pkg::ADDR_STATUS: s_next.rdata = {4'h0, s_reg.status};
        weld_init_pkg::ADDR_ENABLE: s_next.rdata = {4'h0, s_reg.en};
        weld_init_pkg::ADDR_CONTROL: s_next.rdata = {4'h0, s_reg.ctl};
        weld_init_pkg::ADDR_SCHED: s_next.rdata = s_reg.sched;
        weld_init_pkg::ADDR_STATE: s_next.rdata = {3'h0, s_reg.st};
        default: s_next.rdata = 8'h00;
      endcase
    end
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      s_reg.st <= weld_init_pkg::ST_IDLE;
      s_reg.sched <= weld_init_pkg::SCHED_RESET;
      s_reg.ctl <= weld_init_pkg::CONTROL_RESET;
      s_reg.en <= weld_init_pkg::ENABLE_RESET;
      s_reg.status <= '0;
      s_reg.rdata <= 8'h00;
      s_reg.start <= 1'b0;
    end else begin
      s_reg <= s_next;
    end
  end

  // --------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------
  logic running;
  logic welding_ok;
  logic valves_on;
  assign running = (s_reg.st == weld_init_pkg::ST_RUN);
  // Weld only with indicator set and switch closed
  assign welding_ok = s_reg.ctl[weld_init_pkg::CTL_WELD_LED] & weld_sw;
  // Valves during sequence, or first stage while idle in two stage mode
  assign valves_on = running
    | (two_stage & first_stage & (s_reg.st == weld_init_pkg::ST_IDLE));

  assign seq_start_o = s_reg.start;
  assign seq_schedule_o = s_reg.sched;
  assign seq_active_o = running;
  assign solenoid_valve_one_output_o = valves_on & schedule_valves_i[0];
  assign solenoid_valve_two_output_o = valves_on & schedule_valves_i[1];
  assign solenoid_valve_three_output_o = valves_on & schedule_valves_i[2];
  assign weld_current_o = running & weld_interval_i & welding_ok;
  assign no_weld_led_o = ~welding_ok;
  assign estop_o = (s_reg.st == weld_init_pkg::ST_ESTOP);
  assign rdata_o = s_reg.rdata;
  assign irq_o = |(s_reg.status & s_reg.en);

  // --------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------
  AST_ESTOP_ENTRY: assert property (@(posedge clk_i) disable iff (srst_i)
    !loop_ok |=> estop_o)
    else $error("open loop did not force emergency stop");
  AST_ESTOP_OUTPUTS: assert property (@(posedge clk_i) disable iff (srst_i)
    estop_o |-> !weld_current_o && !solenoid_valve_one_output_o && !seq_active_o)
    else $error("outputs live during emergency stop");
  AST_NO_RESTART: assert property (@(posedge clk_i) disable iff (srst_i)
    estop_o && loop_ok |=> !seq_start_o)
    else $error("restart straight out of emergency stop");
  AST_WELD_GATE: assert property (@(posedge clk_i) disable iff (srst_i)
    weld_current_o |-> weld_sw && weld_interval_i)
    else $error("current without weld switch or interval");
  AST_NOWELD_LED: assert property (@(posedge clk_i) disable iff (srst_i)
    !weld_sw |-> no_weld_led_o && !weld_current_o)
    else $error("weld switch open but not in no-weld");
  AST_LATCH: assert property (@(posedge clk_i) disable iff (srst_i)
    seq_active_o && loop_ok && !seq_done_i |=> seq_active_o)
    else $error("sequence dropped before done");
  AST_NO_RESTART_RUN: assert property (@(posedge clk_i) disable iff (srst_i)
    seq_active_o |=> !seq_start_o)
    else $error("start accepted while running");
  AST_THIRD_SCHED: assert property (@(posedge clk_i) disable iff (srst_i)
    $rose(seq_active_o) && !ext_sel && !$past(primary_in) && !$past(second_in)
      |-> seq_schedule_o == weld_init_pkg::SCHED_THIRD_START)
    else $error("third input wrong schedule");
  AST_SECOND_SCHED: assert property (@(posedge clk_i) disable iff (srst_i)
    $rose(seq_active_o) && !ext_sel && !$past(primary_in) && $past(second_in)
      |-> seq_schedule_o == weld_init_pkg::SCHED_SECOND_START)
    else $error("second input wrong schedule");
  AST_EXT_ONLY_PRIMARY: assert property (@(posedge clk_i) disable iff (srst_i)
    s_reg.st == weld_init_pkg::ST_IDLE && ext_sel && !primary_in && loop_ok |=> !seq_start_o)
    else $error("pointer input started sequence");
  AST_FIRST_STAGE: assert property (@(posedge clk_i) disable iff (srst_i)
    s_reg.st == weld_init_pkg::ST_IDLE && two_stage && first_stage && !any_start
      |-> !seq_start_o ##1 !seq_active_o)
    else $error("first stage started a sequence");
  COV_START: cover property (@(posedge clk_i) disable iff (srst_i) seq_start_o);
  COV_REPEAT: cover property (@(posedge clk_i) disable iff (srst_i)
    s_reg.st == weld_init_pkg::ST_DONE ##1 seq_start_o);
  COV_ESTOP: cover property (@(posedge clk_i) disable iff (srst_i) seq_active_o ##1 estop_o);
  COV_WELD: cover property (@(posedge clk_i) disable iff (srst_i) weld_current_o);
endmodule : weld_initiation_sequencer
`default_nettype wire

// ===== shared/weld_init_pkg.sv
// Package: constants and types shared by the weld initiation sequencer
package weld_init_pkg;
  // --------------------------------------------------------------------
  // Schedules
  // --------------------------------------------------------------------
  localparam logic [7:0] SCHED_SECOND_START = 8'h0A; // Schedule 10
  localparam logic [7:0] SCHED_THIRD_START = 8'h14;  // Schedule 20
  localparam logic [7:0] SCHED_RESET = 8'h00;
  localparam logic [7:0] SCHED_EXT_BASE = 8'h00;

  // --------------------------------------------------------------------
  // Timing at 25 MHz
  // --------------------------------------------------------------------
  localparam int CLK_HZ = 25000000;
  localparam int DEBOUNCE_US = 10000;
  localparam int DEBOUNCE_CYCLES = (CLK_HZ / 1000000) * DEBOUNCE_US;
  localparam int SEQ_DONE_WAIT = 0;

  // --------------------------------------------------------------------
  // Register layout: interrupt, control, schedule and state
  // --------------------------------------------------------------------
  localparam logic [3:0] ADDR_STATUS = 4'h0;
  localparam logic [3:0] ADDR_CLEAR = 4'h1;
  localparam logic [3:0] ADDR_ENABLE = 4'h2;
  localparam logic [3:0] ADDR_CONTROL = 4'h3;
  localparam logic [3:0] ADDR_SCHED = 4'h4;
  localparam logic [3:0] ADDR_STATE = 4'h5;
  localparam int EVT_W = 4;
  localparam int EVT_START = 0;
  localparam int EVT_DONE = 1;
  localparam int EVT_ESTOP = 2;
  localparam int EVT_RELEASE = 3;
  localparam logic [3:0] ENABLE_RESET = 4'h0;
  localparam logic [3:0] CONTROL_RESET = 4'h0;
  localparam int CTL_EXT_SEL = 0;
  localparam int CTL_TWO_STAGE = 1;
  localparam int CTL_REPEAT = 2;
  localparam int CTL_WELD_LED = 3;

  // --------------------------------------------------------------------
  // Sequencer states
  // --------------------------------------------------------------------
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_RUN = 5'h02,
    ST_DONE = 5'h04,
    ST_ESTOP = 5'h08,
    ST_WAIT_OPEN = 5'h10
  } seq_state_t;
endpackage : weld_init_pkg

// ===== hw/contact_debounce.sv
// Contact input synchroniser and debouncer
`timescale 1ns/1ns
`default_nettype none
module contact_debounce #(
  parameter int COUNT = 250000
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // Raw contact and clean level
  input wire logic raw_i,
  output logic clean_o
);
  localparam int CW = $clog2(COUNT + 1);
  typedef struct packed {
    logic s1;
    logic s2;
    logic level;
    logic [CW-1:0] cnt;
  } db_t;
  db_t db_reg;
  db_t db_next;

  // Two stage sync, then level must hold COUNT cycles
  always_comb begin
    db_next = db_reg;
    db_next.s1 = raw_i;
    db_next.s2 = db_reg.s1;
    if (db_reg.s2 == db_reg.level) begin
      db_next.cnt = '0;
    end else if (db_reg.cnt == CW'(COUNT - 1)) begin
      db_next.level = db_reg.s2;
      db_next.cnt = '0;
    end else begin
      db_next.cnt = db_reg.cnt + CW'(1);
    end
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      db_reg <= '0;
    end else begin
      db_reg <= db_next;
    end
  end

  assign clean_o = db_reg.level;
endmodule : contact_debounce
`default_nettype wire

// ===== testbench/operator_switches.sv
// Operator switch model: pilot switches, series stop loop and weld switch
`timescale 1ns/1ns
`default_nettype none
module operator_switches (
  // Clock
  input wire logic clk_i,
  // Bench commands, high = pressed; pilot order {third, second, primary, first}
  input wire logic [3:0] pilot_i,
  input wire logic [1:0] stop_pressed_i,
  input wire logic weld_closed_i,
  // Contact levels at the strip, high = closed
  output logic [5:0] contact_o
);
  logic [5:0] cmd;
  logic [5:0] prev_reg = 6'h00;
  logic [5:0] chg_reg = 6'h00;
  logic [1:0] cnt_reg = 2'h0;

  // Any pressed stop switch opens the series loop
  assign cmd = {weld_closed_i, ~|stop_pressed_i, pilot_i};

  // Changed contacts chatter for a few cycles, shorter than the filter
  always_ff @(posedge clk_i) begin
    prev_reg <= cmd;
    if (cmd != prev_reg) begin
      chg_reg <= cmd ^ prev_reg;
      cnt_reg <= 2'h3;
    end else if (cnt_reg != 2'h0) begin
      cnt_reg <= cnt_reg - 2'h1;
    end
  end
  assign contact_o = cmd ^ (chg_reg & {6{cnt_reg[0]}});
endmodule : operator_switches
`default_nettype wire

// ===== testbench/weld_initiation_sequencer_tb_top.sv
// Self-checking testbench for the weld initiation sequencer
`timescale 1ns/1ns
`default_nettype none
module weld_initiation_sequencer_tb_top;
  // --------------------------------------------------------------------
  // Signals
  // --------------------------------------------------------------------
  localparam int DEB = 4;
  localparam logic [7:0] DISP = 8'h37;
  localparam logic [7:0] C_EXT = 8'h01 << weld_init_pkg::CTL_EXT_SEL;
  localparam logic [7:0] C_TWO = 8'h01 << weld_init_pkg::CTL_TWO_STAGE;
  localparam logic [7:0] C_REP = 8'h01 << weld_init_pkg::CTL_REPEAT;
  localparam logic [7:0] C_LED = 8'h01 << weld_init_pkg::CTL_WELD_LED;
  logic clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic [3:0] pil = 4'h0;
  logic [1:0] stop_pr = 2'h0;
  logic weld_sw = 1'b1;
  logic interval = 1'b0;
  logic [2:0] valves = 3'h5;
  logic done = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [5:0] contact;
  logic start, active, valve_a, valve_b, valve_c, current, nw_led, estop, irq;
  logic [7:0] sched, rdata;
  int errors = 0;
  int n_compared = 0;
  int cycles = 0;

  // Clock
  always #20 clk_i = ~clk_i;

  operator_switches operator_switches_inst (.clk_i(clk_i), .pilot_i(pil),
    .stop_pressed_i(stop_pr), .weld_closed_i(weld_sw), .contact_o(contact));
  weld_initiation_sequencer #(.DEBOUNCE(DEB)) weld_initiation_sequencer_inst (
    .clk_i(clk_i), .srst_i(srst_i), .first_stage_pilot_input_i(contact[0]),
    .primary_initiate_input_i(contact[1]), .second_initiate_pointer_low_i(contact[2]),
    .third_initiate_pointer_high_i(contact[3]), .emergency_stop_loop_input_i(contact[4]),
    .weld_enable_switch_input_i(contact[5]), .display_schedule_i(DISP),
    .weld_interval_i(interval), .schedule_valves_i(valves), .seq_done_i(done),
    .seq_start_o(start), .seq_schedule_o(sched), .seq_active_o(active),
    .solenoid_valve_one_output_o(valve_a), .solenoid_valve_two_output_o(valve_b),
    .solenoid_valve_three_output_o(valve_c), .weld_current_o(current), .no_weld_led_o(nw_led),
    .estop_o(estop), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
    .rdata_o(rdata), .irq_o(irq));

  // --------------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic end_of_test;
    if (errors == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_of_test

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask : tick

  task automatic set_pil(input logic [3:0] v);
    @(posedge clk_i);
    pil <= v;
  endtask : set_pil

  task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_i);
    wr <= 1'b0;
  endtask : reg_wr

  task automatic reg_rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_i);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : reg_rd

  // Bounded wait for a start pulse
  task automatic see_start(input int n, output logic got);
    got = 1'b0;
    for (int i = 0; i < n && !got; i++) begin
      @(negedge clk_i);
      got = (start === 1'b1);
    end
  endtask : see_start

  // Timing core reports the end of the sequence
  task automatic finish_seq;
    @(posedge clk_i);
    done <= 1'b1;
    @(posedge clk_i);
    done <= 1'b0;
    @(negedge clk_i);
  endtask : finish_seq

  // --------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------
  task automatic s_single;
    logic got;
    logic [3:0] pats [3] = '{4'h2, 4'h4, 4'h8};
    logic [7:0] exps [3] = '{DISP, weld_init_pkg::SCHED_SECOND_START,
                              weld_init_pkg::SCHED_THIRD_START};
    for (int i = 0; i < 3; i++) begin
      set_pil(pats[i]);
      see_start(40, got);
      check(got, 1'b1);
      check(sched, exps[i]);
      set_pil(4'h0);
      tick(15);
      check(active, 1'b1);
      set_pil(4'hE);
      see_start(20, got);
      check(got, 1'b0);
      set_pil(4'h0);
      tick(12);
      finish_seq();
      check(active, 1'b0);
    end
  endtask : s_single

  task automatic s_repeat;
    logic got;
    reg_wr(weld_init_pkg::ADDR_CONTROL, C_REP);
    set_pil(4'h2);
    see_start(40, got);
    finish_seq();
    see_start(20, got);
    check(got, 1'b1);
    set_pil(4'h0);
    tick(12);
    finish_seq();
    see_start(20, got);
    check(got, 1'b0);
  endtask : s_repeat

  task automatic s_two_stage;
    logic got;
    reg_wr(weld_init_pkg::ADDR_CONTROL, C_TWO | C_REP);
    set_pil(4'h1);
    tick(12);
    check({valve_c, valve_b, valve_a}, valves);
    check(active, 1'b0);
    set_pil(4'h9);
    see_start(40, got);
    check(sched, weld_init_pkg::SCHED_THIRD_START);
    set_pil(4'h8);
    tick(12);
    check(active, 1'b1);
    finish_seq();
    see_start(20, got);
    check(got, 1'b1);
    set_pil(4'h0);
    tick(12);
    finish_seq();
    see_start(20, got);
    check(got, 1'b0);
  endtask : s_two_stage

  task automatic s_ext_select;
    logic got;
    reg_wr(weld_init_pkg::ADDR_CONTROL, C_EXT);
    for (int p = 0; p < 4; p++) begin
      set_pil({p[1:0], 2'b00});
      see_start(15, got);
      check(got, 1'b0);
      set_pil({p[1:0], 2'b10});
      see_start(40, got);
      check(sched, weld_init_pkg::SCHED_EXT_BASE + 8'(p));
      set_pil({~p[1:0], 2'b10});
      tick(12);
      check(sched, weld_init_pkg::SCHED_EXT_BASE + 8'(p));
      set_pil(4'h0);
      tick(12);
      finish_seq();
    end
  endtask : s_ext_select

  task automatic s_weld;
    logic got;
    reg_wr(weld_init_pkg::ADDR_CONTROL, C_LED);
    set_pil(4'h2);
    see_start(40, got);
    check({current, nw_led}, 2'b00);
    @(posedge clk_i);
    interval <= 1'b1;
    @(negedge clk_i);
    check(current, 1'b1);
    @(posedge clk_i);
    weld_sw <= 1'b0;
    tick(12);
    check({current, nw_led, active}, 3'b011);
    @(posedge clk_i);
    weld_sw <= 1'b1;
    reg_wr(weld_init_pkg::ADDR_CONTROL, 8'h00);
    tick(12);
    check({current, nw_led, active}, 3'b011);
    interval <= 1'b0;
    set_pil(4'h0);
    tick(12);
    finish_seq();
  endtask : s_weld

  task automatic s_estop;
    logic got;
    logic [7:0] d;
    reg_wr(weld_init_pkg::ADDR_ENABLE, 8'h01 << weld_init_pkg::EVT_ESTOP);
    // Flush events left from earlier scenarios so the interrupt is earned here
    reg_wr(weld_init_pkg::ADDR_CLEAR, 8'h0F);
    reg_rd(weld_init_pkg::ADDR_ENABLE, d);
    check(d, 8'h01 << weld_init_pkg::EVT_ESTOP);
    reg_rd(4'hF, d);
    check(d, 8'h00);
    set_pil(4'h3);
    see_start(40, got);
    @(posedge clk_i);
    stop_pr <= 2'b10;
    tick(12);
    check({estop, active, valve_c, valve_b, valve_a, current}, 6'h20);
    check(irq, 1'b1);
    stop_pr <= 2'b00;
    see_start(30, got);
    check(got, 1'b0);
    reg_rd(weld_init_pkg::ADDR_STATE, d);
    check(d, 8'(weld_init_pkg::ST_WAIT_OPEN));
    reg_wr(weld_init_pkg::ADDR_CLEAR, 8'h01 << weld_init_pkg::EVT_ESTOP);
    @(negedge clk_i);
    check(irq, 1'b0);
    // Start and release events stay sticky after the stop bit is cleared
    reg_rd(weld_init_pkg::ADDR_STATUS, d);
    check(d, (8'h01 << weld_init_pkg::EVT_START) | (8'h01 << weld_init_pkg::EVT_RELEASE));
    set_pil(4'h0);
    tick(12);
    set_pil(4'h2);
    see_start(40, got);
    check(got, 1'b1);
    set_pil(4'h0);
    tick(12);
    finish_seq();
    reg_rd(weld_init_pkg::ADDR_SCHED, d);
    check(d, DISP);
  endtask : s_estop

  // --------------------------------------------------------------------
  // Main sequence and timeout
  // --------------------------------------------------------------------
  initial begin
    logic [7:0] d;
    tick(2);
    srst_i <= 1'b0;
    tick(30);
    reg_rd(weld_init_pkg::ADDR_STATE, d);
    check(d, 8'(weld_init_pkg::ST_IDLE));
    s_single();
    s_repeat();
    s_two_stage();
    s_ext_select();
    s_weld();
    s_estop();
    end_of_test();
  end

  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      $display("MISMATCH t=%0t run did not finish", $time);
      end_of_test();
    end
  end
endmodule : weld_initiation_sequencer_tb_top
`default_nettype wire
